// ### hw/hsi_regs.vh
// Purpose: offsets, fields, reset values and timing counts of the hub status and strap block
// Assumes: AXI4-Lite, 32-bit data, 50 MHz aclk
// Notes: offsets are byte addresses
`ifndef HSI_REGS_VH
`define HSI_REGS_VH

`define HSI_ADDR_W          6
`define HSI_OFF_CTRL        6'h00
`define HSI_OFF_STATUS      6'h04
`define HSI_OFF_LED         6'h08
`define HSI_OFF_STRAP       6'h0C
`define HSI_OFF_WAKE        6'h10

// control register fields
`define HSI_CTRL_CONFIGURED 0
`define HSI_CTRL_SUSPENDED  1
`define HSI_CTRL_HIGH_SPEED 2
`define HSI_CTRL_CONNECTED  3
`define HSI_CTRL_WAKE_MODE  4
`define HSI_CTRL_RESET      32'h0000_0000

// led register fields
`define HSI_LED_ENABLE      0
`define HSI_LED_BREATHE     1
`define HSI_LED_RATE_LO     4
`define HSI_LED_RATE_HI     5
`define HSI_LED_RESET       32'h0000_0000

// wake register: write 1 to bit 0 requests a wakeup pulse
`define HSI_WAKE_REQ        0

// timing
`define HSI_CLK_HZ          50000000
`define HSI_TICK_US         1
`define HSI_TICK_CYC        (`HSI_CLK_HZ / 1000000 * `HSI_TICK_US)
`define HSI_WAKE_US         2
`define HSI_WAKE_CYC        (`HSI_CLK_HZ / 1000000 * `HSI_WAKE_US)
`define HSI_RENEG_US        10
`define HSI_RENEG_CYC       (`HSI_CLK_HZ / 1000000 * `HSI_RENEG_US)

`define HSI_RESP_OKAY       2'b00
`define HSI_RESP_SLVERR     2'b10

`endif

// ### hw/hsi_led_gen.v
// Purpose: blink or breathe pattern generator for the general purpose led
// Assumes: tick is a one-cycle enable of 1 us
// Notes: breathing is an 8-bit pwm whose duty ramps up and down
`timescale 1ns/1ps
`include "hsi_regs.vh"
module hsi_led_gen (
    input  wire       aclk,
    input  wire       aresetn,
    input  wire       tick,
    input  wire       enable,
    input  wire       breathe,
    input  wire [1:0] rate,
    output reg        led_on
);
    reg  [7:0]  pwm_cnt;
    reg  [17:0] step_cnt;
    reg  [7:0]  duty;
    reg         duty_down;
    wire [17:0] step_len;

    // each rate halves the step time; blink period is 512 steps
    assign step_len = 18'h0_0400 >> rate;

    always @(posedge aclk) begin
        if (!aresetn || !enable) begin
            pwm_cnt   <= 8'h00;
            step_cnt  <= 18'h0_0000;
            duty      <= 8'h00;
            duty_down <= 1'b0;
            led_on    <= 1'b0;
        end else if (tick) begin
            pwm_cnt <= pwm_cnt + 8'h01;
            if (step_cnt >= step_len - 18'h0_0001) begin
                step_cnt <= 18'h0_0000;
                if (duty_down) begin
                    if (duty == 8'h00)
                        duty_down <= 1'b0;
                    else
                        duty <= duty - 8'h01;
                end else begin
                    if (duty == 8'hFF)
                        duty_down <= 1'b1;
                    else
                        duty <= duty + 8'h01;
                end
            end else begin
                step_cnt <= step_cnt + 18'h0_0001;
            end
            led_on <= breathe ? (pwm_cnt < duty) : duty_down;
        end
    end
endmodule // hsi_led_gen

// ### hw/hsi_top.v
// Purpose: side-band status indicators and strap capture of a three-port hub
// Assumes: single 50 MHz clock, synchronous active-low reset, AXI4-Lite register access
// Notes: the hub core state arrives through the control register written by firmware
`timescale 1ns/1ps
`include "hsi_regs.vh"
module hsi_top (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [5:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [5:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        self_power_detect,
    input  wire        upstream_power_detect,
    input  wire        config_method_strap_b0,
    input  wire        config_method_strap_b1,
    input  wire        fixed_port_strap_b0,
    input  wire        fixed_port_strap_b1,
    output reg         suspend_wake_indicator_o,
    output reg         suspend_wake_indicator_oe,
    output reg         high_speed_indicator,
    output reg         general_led_out,
    output reg         reconnect_req,
    output reg  [1:0]  config_method,
    output reg  [1:0]  fixed_port_sel,
    output reg         self_powered
);
    // pin synchronisers: stage one feeds only stage two
    reg  [5:0]  sync_a;
    reg  [5:0]  sync_b;
    reg         vbus_prev;
    reg         straps_taken;
    reg         strap_cfg1;
    reg  [31:0] ctrl;
    reg  [31:0] led_cfg;
    reg  [5:0]  tick_cnt;
    reg         tick;
    reg  [7:0]  wake_cnt;
    reg         wake_pending;
    reg  [9:0]  reneg_cnt;
    reg         aw_held;
    reg         w_held;
    reg  [5:0]  aw_addr;
    reg  [31:0] w_data;
    reg  [3:0]  w_strb;
    wire        led_on;
    wire        susp_level;
    wire        hs_active;
    // full-width timing counts, cut to the counter widths on purpose below
    wire [31:0] reneg_len = `HSI_RENEG_CYC;
    wire [31:0] wake_len  = `HSI_WAKE_CYC;

    function [31:0] hsi_merge;
        input [31:0] old_val;
        input [31:0] new_val;
        input [3:0]  strb;
        integer i;
        begin
            hsi_merge = old_val;
            for (i = 0; i < 4; i = i + 1)
                if (strb[i])
                    hsi_merge[i*8 +: 8] = new_val[i*8 +: 8];
        end
    endfunction

    always @(posedge aclk) begin
        if (!aresetn) begin
            sync_a <= 6'h00;
            sync_b <= 6'h00;
        end else begin
            sync_a <= {fixed_port_strap_b1, fixed_port_strap_b0, config_method_strap_b1,
                       config_method_strap_b0, upstream_power_detect, self_power_detect};
            sync_b <= sync_a;
        end
    end

    // 1 us enable for the led generator
    always @(posedge aclk) begin
        if (!aresetn) begin
            tick_cnt <= 6'h00;
            tick     <= 1'b0;
        end else if (tick_cnt == `HSI_TICK_CYC - 1) begin
            tick_cnt <= 6'h00;
            tick     <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 6'h01;
            tick     <= 1'b0;
        end
    end

    // straps are caught at the third edge after release, once stage two holds pin levels;
    // catching earlier would latch the cleared synchroniser instead of the pins
    reg  [1:0]  strap_wait;
    always @(posedge aclk) begin
        if (!aresetn) begin
            strap_wait     <= 2'b00;
            straps_taken   <= 1'b0;
            config_method  <= 2'b00;
            fixed_port_sel <= 2'b00;
            strap_cfg1     <= 1'b0;
        end else begin
            strap_wait <= {strap_wait[0], 1'b1};
            if (strap_wait[1] && !straps_taken) begin
                straps_taken   <= 1'b1;
                config_method  <= {sync_b[3], sync_b[2]};
                fixed_port_sel <= {sync_b[5], sync_b[4]};
                strap_cfg1     <= sync_b[3];
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn)
            self_powered <= 1'b0;
        else
            self_powered <= sync_b[0];
    end

    // any edge on upstream power after the straps are taken starts a reconnect pulse; registers are kept
    always @(posedge aclk) begin
        if (!aresetn) begin
            vbus_prev     <= 1'b0;
            reneg_cnt     <= 10'h000;
            reconnect_req <= 1'b0;
        end else begin
            vbus_prev <= sync_b[1];
            if (straps_taken && (vbus_prev != sync_b[1])) begin
                reneg_cnt     <= reneg_len[9:0];
                reconnect_req <= 1'b1;
            end else if (reneg_cnt != 10'h000) begin
                reneg_cnt     <= reneg_cnt - 10'h001;
                reconnect_req <= (reneg_cnt != 10'h001);
            end else begin
                reconnect_req <= 1'b0;
            end
        end
    end

    // axi4-lite write path: address and data taken in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 6'h00;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `HSI_RESP_OKAY;
            ctrl          <= `HSI_CTRL_RESET;
            led_cfg       <= `HSI_LED_RESET;
            wake_pending  <= 1'b0;
        end else begin
            wake_pending  <= 1'b0;
            s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready  <= !w_held && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held       <= 1'b1;
                aw_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held       <= 1'b1;
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (aw_held && w_held && !s_axi_bvalid) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `HSI_RESP_OKAY;
                case ({aw_addr[5:2], 2'b00})
                    `HSI_OFF_CTRL:   ctrl    <= hsi_merge(ctrl, w_data, w_strb) & 32'h0000_001F;
                    `HSI_OFF_LED:    led_cfg <= hsi_merge(led_cfg, w_data, w_strb) & 32'h0000_0033;
                    `HSI_OFF_WAKE:   wake_pending <= w_strb[0] & w_data[`HSI_WAKE_REQ];
                    `HSI_OFF_STATUS: s_axi_bresp <= `HSI_RESP_OKAY;
                    `HSI_OFF_STRAP:  s_axi_bresp <= `HSI_RESP_OKAY;
                    default:         s_axi_bresp <= `HSI_RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // axi4-lite read path
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `HSI_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= `HSI_RESP_OKAY;
                case ({s_axi_araddr[5:2], 2'b00})
                    `HSI_OFF_CTRL:   s_axi_rdata <= ctrl;
                    `HSI_OFF_LED:    s_axi_rdata <= led_cfg;
                    `HSI_OFF_STATUS: s_axi_rdata <= {26'h000_0000, reconnect_req, general_led_out,
                                                     high_speed_indicator, suspend_wake_indicator_oe,
                                                     sync_b[1], self_powered};
                    `HSI_OFF_STRAP:  s_axi_rdata <= {27'h000_0000, straps_taken, fixed_port_sel,
                                                     config_method};
                    `HSI_OFF_WAKE:   s_axi_rdata <= 32'h0000_0000;
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `HSI_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // wakeup pulse: in wake mode the line is pulled low for a fixed time per request
    always @(posedge aclk) begin
        if (!aresetn)
            wake_cnt <= 8'h00;
        else if (wake_pending && ctrl[`HSI_CTRL_WAKE_MODE])
            wake_cnt <= wake_len[7:0];
        else if (wake_cnt != 8'h00)
            wake_cnt <= wake_cnt - 8'h01;
    end

    // suspend mode: high only when configured and not suspended
    assign susp_level = ctrl[`HSI_CTRL_WAKE_MODE] ? (wake_cnt == 8'h00)
                      : (ctrl[`HSI_CTRL_CONFIGURED] && !ctrl[`HSI_CTRL_SUSPENDED]);
    assign hs_active  = ctrl[`HSI_CTRL_CONNECTED] && ctrl[`HSI_CTRL_HIGH_SPEED];

    // open-drain: the pin is only driven when low
    always @(posedge aclk) begin
        if (!aresetn) begin
            suspend_wake_indicator_o  <= 1'b0;
            suspend_wake_indicator_oe <= 1'b1;
            high_speed_indicator      <= 1'b0;
            general_led_out           <= 1'b0;
        end else begin
            suspend_wake_indicator_o  <= 1'b0;
            suspend_wake_indicator_oe <= !susp_level;
            high_speed_indicator      <= hs_active ^ strap_cfg1;
            general_led_out           <= led_on;
        end
    end

    hsi_led_gen u_led (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tick    (tick),
        .enable  (led_cfg[`HSI_LED_ENABLE]),
        .breathe (led_cfg[`HSI_LED_BREATHE]),
        .rate    (led_cfg[`HSI_LED_RATE_HI:`HSI_LED_RATE_LO]),
        .led_on  (led_on)
    );
endmodule // hsi_top

// ### testbench/hsi_top_props.sv
// Purpose: concurrent checks on the ports of the hub status and strap block
// Assumes: one clock, synchronous active-low reset
// Notes: bound to hsi_top below
`timescale 1ns/1ps
module hsi_top_props (
    input wire        aclk,
    input wire        aresetn,
    input wire        s_axi_awready,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire        s_axi_arready,
    input wire        s_axi_rvalid,
    input wire        self_power_detect,
    input wire        upstream_power_detect,
    input wire        suspend_wake_indicator_o,
    input wire        reconnect_req,
    input wire [1:0]  config_method,
    input wire [1:0]  fixed_port_sel,
    input wire        self_powered
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    reg [9:0] hi_cnt;
    reg [2:0] since_rst;
    always @(posedge aclk) begin
        if (!aresetn || !reconnect_req) hi_cnt <= 10'h000;
        else hi_cnt <= hi_cnt + 10'h001;
    end
    // saturates so strap checks start once the latch has settled
    always @(posedge aclk) begin
        if (!aresetn) since_rst <= 3'h0;
        else if (since_rst != 3'h7) since_rst <= since_rst + 3'h1;
    end
    AST_OD_LOW: assert property (suspend_wake_indicator_o == 1'b0)
        else $error("suspend pin data not low");
    AST_SELF_PWR: assert property ($stable(self_power_detect)[*6] |-> self_powered == self_power_detect)
        else $error("self power flag does not follow pin");
    AST_RECONN_LEN: assert property ($fell(reconnect_req) |-> hi_cnt == 10'd500)
        else $error("reconnect pulse length wrong");
    AST_RECONN_MAX: assert property (reconnect_req |-> hi_cnt < 10'd500)
        else $error("reconnect pulse too long");
    AST_RECONN_CAUSE: assert property (since_rst == 3'h7 && !reconnect_req && $changed(upstream_power_detect)
        |-> ##[1:6] reconnect_req)
        else $error("bus power edge gave no reconnect");
    AST_STRAP_HOLD: assert property (since_rst == 3'h7 |-> $stable(config_method) && $stable(fixed_port_sel))
        else $error("latched straps changed");
    AST_B_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    AST_R_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
endmodule // hsi_top_props

bind hsi_top hsi_top_props u_props (.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .self_power_detect(self_power_detect), .upstream_power_detect(upstream_power_detect),
    .suspend_wake_indicator_o(suspend_wake_indicator_o), .reconnect_req(reconnect_req),
    .config_method(config_method), .fixed_port_sel(fixed_port_sel), .self_powered(self_powered));

// ### testbench/hsi_host_model.sv
// Purpose: upstream host and board model for the hub status block
// Assumes: board pull-up on the open-drain suspend pin
// Notes: bus power is flipped only on request
`timescale 1ns/1ps
module hsi_host_model (
    input  wire aclk,
    input  wire flip,
    input  wire od_o,
    input  wire od_oe,
    output reg  upstream_power_detect,
    output wire susp_pin
);
    initial upstream_power_detect = 1'b1;
    // an embedded host flips bus power to force renegotiation
    always @(posedge aclk) begin
        if (flip) upstream_power_detect <= !upstream_power_detect;
    end
    assign susp_pin = od_oe ? od_o : 1'b1;
endmodule // hsi_host_model

// ### testbench/tb_hub_status_indicator_straps.sv
// Purpose: self-checking bench for the hub status and strap block
// Assumes: 50 MHz aclk, straps steady before reset release
// Notes: slow blink counts are not timed, only breathing activity
`timescale 1ns/1ps
`include "hsi_regs.vh"
module tb_hub_status_indicator_straps;
    reg aclk = 0, aresetn = 0, flip = 0, self_power_detect = 0;
    reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    reg [5:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    reg [31:0] s_axi_wdata = 0;
    reg [3:0] s_axi_wstrb = 4'hf;
    reg config_method_strap_b0 = 0, config_method_strap_b1 = 0, fixed_port_strap_b0 = 0, fixed_port_strap_b1 = 0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, upstream_power_detect, susp_pin;
    wire [1:0] s_axi_bresp, s_axi_rresp, config_method, fixed_port_sel;
    wire [31:0] s_axi_rdata;
    wire suspend_wake_indicator_o, suspend_wake_indicator_oe, high_speed_indicator;
    wire general_led_out, reconnect_req, self_powered;
    integer num_errors = 0, samples_checked = 0, cycles = 0, seed = 32'h2b5c_9d13;
    integer i, p, n, v, run = 0, last = 0, led_hi = 0;
    reg [4:0] es;
    hsi_top dut (.*);
    hsi_host_model u_host (.aclk(aclk), .flip(flip), .od_o(suspend_wake_indicator_o),
        .od_oe(suspend_wake_indicator_oe), .upstream_power_detect(upstream_power_detect), .susp_pin(susp_pin));
    always #10 aclk = ~aclk;
    always @(posedge aclk) begin
        cycles = cycles + 1;
        if (general_led_out === 1'b1) led_hi = led_hi + 1;
        if (suspend_wake_indicator_oe === 1'b1) run = run + 1;
        else if (run != 0) begin
            last = run;
            run = 0;
        end
        if (cycles == 90000) begin
            num_errors = num_errors + 1;
            conclude;
        end
    end
    task conclude;
        begin
            $display("checks %0d errors %0d", samples_checked, num_errors);
            if (num_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
            else $display("Run complete: FAIL");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp, input [8*8:1] what);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("Error %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    // master holds each channel until its own ready is sampled high
    task wchk(input [5:0] a, input [31:0] d, input [1:0] er);
        begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1;
            s_axi_wvalid <= 1;
            s_axi_bready <= 1;
            // requests are non-blocking, so the first look at them comes after an edge
            do begin
                @(posedge aclk);
                if (s_axi_awready) s_axi_awvalid <= 0;
                if (s_axi_wready) s_axi_wvalid <= 0;
                if (s_axi_bvalid && s_axi_bready && !s_axi_awvalid && !s_axi_wvalid) begin
                    chk(s_axi_bresp, er, "bresp");
                    s_axi_bready <= 0;
                end
            end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
        end
    endtask
    task rchk(input [5:0] a, input [31:0] ed, input [1:0] er);
        begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1;
            s_axi_rready <= 1;
            do begin
                @(posedge aclk);
                if (s_axi_arready) s_axi_arvalid <= 0;
                if (s_axi_rvalid && s_axi_rready && !s_axi_arvalid) begin
                    chk(s_axi_rdata, ed, "rdata");
                    chk(s_axi_rresp, er, "rresp");
                    s_axi_rready <= 0;
                end
            end while (s_axi_arvalid || s_axi_rready);
        end
    endtask
    initial begin
        @(posedge aclk);
        for (p = 0; p < 2; p = p + 1) begin
            aresetn <= 0;
            v = $random(seed);
            {config_method_strap_b0, fixed_port_strap_b1, fixed_port_strap_b0} <= v[2:0];
            config_method_strap_b1 <= p[0];
            repeat (3) @(posedge aclk);
            aresetn <= 1;
            es = {1'b1, v[1], v[0], p[0], v[2]};
            repeat (4) @(posedge aclk);
            {config_method_strap_b0, fixed_port_strap_b1, fixed_port_strap_b0, config_method_strap_b1} <= ~{v[2:0], p[0]};
            repeat (6) @(posedge aclk);
            chk(config_method, es[1:0], "cfg");
            chk(fixed_port_sel, es[3:2], "fixed");
            rchk(`HSI_OFF_STRAP, es, `HSI_RESP_OKAY);
            rchk(`HSI_OFF_LED, `HSI_LED_RESET, `HSI_RESP_OKAY);
            for (i = 0; i < 16; i = i + 1) begin
                wchk(`HSI_OFF_CTRL, i, `HSI_RESP_OKAY);
                repeat (4) @(posedge aclk);
                chk(susp_pin, i[0] & !i[1], "susp");
                chk(high_speed_indicator, (i[2] & i[3]) ^ p[0], "hs");
                rchk(`HSI_OFF_CTRL, i, `HSI_RESP_OKAY);
            end
            $display("straps and indicators pass %0d done", p);
        end
        for (i = 0; i < 4; i = i + 1) begin
            v = $random(seed);
            self_power_detect <= v[0];
            repeat (8) @(posedge aclk);
            chk(self_powered, v[0], "selfpwr");
        end
        rchk(6'h14, 32'h0000_0000, `HSI_RESP_SLVERR);
        wchk(6'h3C, 32'h0000_0001, `HSI_RESP_SLVERR);
        flip <= 1;
        @(posedge aclk);
        flip <= 0;
        n = 0;
        while (!reconnect_req && n < 20) begin
            @(posedge aclk);
            n = n + 1;
        end
        n = 0;
        while (reconnect_req && n < 600) begin
            @(posedge aclk);
            n = n + 1;
        end
        chk(n, 500, "reconn");
        rchk(`HSI_OFF_CTRL, 15, `HSI_RESP_OKAY);
        chk(config_method, es[1:0], "cfg");
        $display("power and renegotiation done");
        wchk(`HSI_OFF_CTRL, 32'h0000_0011, `HSI_RESP_OKAY);
        repeat (4) @(posedge aclk);
        chk(susp_pin, 1, "wakeidle");
        last = 0;
        wchk(`HSI_OFF_WAKE, 32'h0000_0001, `HSI_RESP_OKAY);
        repeat (300) @(posedge aclk);
        chk(last, 100, "wakelen");
        $display("wake indication done");
        chk(led_hi, 0, "ledoff");
        for (i = 0; i < 4; i = i + 1) begin
            v = $random(seed) & 32'h0000_0032;
            wchk(`HSI_OFF_LED, v, `HSI_RESP_OKAY);
            rchk(`HSI_OFF_LED, v, `HSI_RESP_OKAY);
        end
        chk(led_hi, 0, "ledoff");
        wchk(`HSI_OFF_LED, 32'h0000_0033, `HSI_RESP_OKAY);
        n = 0;
        while (led_hi == 0 && n < 40000) begin
            @(posedge aclk);
            n = n + 1;
        end
        chk(led_hi != 0, 1, "ledon");
        wchk(`HSI_OFF_LED, 32'h0000_0000, `HSI_RESP_OKAY);
        repeat (4) @(posedge aclk);
        chk(general_led_out, 0, "ledoff2");
        $display("led done");
        conclude;
    end
endmodule // tb_hub_status_indicator_straps
